/* src/thermal_cfg_pkg.sv */
// Package with pointers, field positions, reset values and carrier types of the sensor register bank
//
// Summary of operation
// R1 - Capability at pointer zero, read-only, upper zero
// R2 - Capability bits 4:3 mirror selected resolution
// R3 - Capability bit 2 reads one
// R4 - Capability bit 1 reads one
// R5 - Capability bit 0 always reads one
// R6 - Configuration at pointer one, bits 15:11 zero
// R7 - Bits 10:9 select limit hysteresis
// R8 - Hysteresis frozen while any lock set
// R9 - Bit 8 selects shutdown, stopping conversion
// R10 - Registers stay accessible during shutdown
// R11 - Shutdown not settable locked, clearable always
// R12 - Bit 7 locks critical limit writes
// R13 - Bit 6 locks upper and lower limits
// R14 - Locks sticky until power-on reset
// R15 - One write sets a lock
// R16 - Bit 5 write-one clears interrupt, reads zero
// R17 - Bit 4 reports event output asserted
// R18 - Bit 3 enables event output
// R19 - Enable, polarity, mode frozen while locked
// R20 - Bit 2 critical-only select, frozen by window lock
// R21 - Bit 1 sets event pin polarity
// R22 - Bit 0 selects comparator or interrupt
// R23 - Host writes eight-bit pointer before data
package thermal_cfg_pkg;

  // Register pointers
  localparam logic [7:0] PTR_CAPABILITY = 8'h00;
  localparam logic [7:0] PTR_CONFIGURATION = 8'h01;
  localparam logic [7:0] PTR_UPPER_LIMIT = 8'h02;
  localparam logic [7:0] PTR_LOWER_LIMIT = 8'h03;
  localparam logic [7:0] PTR_CRITICAL_LIMIT = 8'h04;

  // Capability field positions
  localparam int CAP_RES_LSB = 3;
  localparam int CAP_RANGE = 2;
  localparam int CAP_ACCURACY = 1;
  localparam int CAP_ALARM = 0;

  // Configuration field positions
  localparam int CFG_HYST_LSB = 9;
  localparam int CFG_SHUTDOWN = 8;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_WIN_LOCK = 6;
  localparam int CFG_INT_CLEAR = 5;
  localparam int CFG_EVT_STAT = 4;
  localparam int CFG_EVT_EN = 3;
  localparam int CFG_EVT_SEL = 2;
  localparam int CFG_EVT_POL = 1;
  localparam int CFG_EVT_MODE = 0;

  // Reset values
  localparam logic [1:0] RES_RESET = 2'h1;
  localparam logic [1:0] HYST_RESET = 2'h0;
  localparam logic CFG_BIT_RESET = 1'h0;

  // Request from the link side to the register core
  typedef struct packed {
    logic is_write;
    logic [7:0] ptr;
    logic [15:0] data;
  } link_req_s;

  // Event trip levels from the comparator logic
  typedef struct packed {
    logic crit;
    logic upper;
    logic lower;
  } trip_s;

  // Limit register write forwarded to the limit storage
  typedef struct packed {
    logic valid;
    logic [7:0] ptr;
    logic [15:0] data;
  } limit_wr_s;

endpackage

/* src/toggle_word_sync.sv */
// Toggle handshake that carries one word from a source clock into a destination clock
`timescale 1ns/1ps
module toggle_word_sync #(
  parameter int WIDTH = 16
) (
  // Clocks and reset
  input wire logic src_clk,
  input wire logic dst_clk,
  input wire logic resetn,
  // Source side
  input wire logic src_send,
  input wire logic [WIDTH-1:0] src_data,
  // Destination side
  output logic dst_valid,
  output logic [WIDTH-1:0] dst_data
);

  logic toggle_q, toggle_d;
  logic [WIDTH-1:0] hold_q, hold_d;
  logic meta_q, sync_q, last_q;
  logic dst_valid_d;
  logic [WIDTH-1:0] dst_data_d;

  // Source: hold the word and flip the toggle; sender must not resend before an answer
  always_comb begin
    toggle_d = toggle_q;
    hold_d = hold_q;
    if (src_send) begin
      toggle_d = ~toggle_q;
      hold_d = src_data;
    end
  end

  always_ff @(posedge src_clk or negedge resetn) begin
    if (!resetn) begin
      toggle_q <= 1'b0;
      hold_q <= '0;
    end else begin
      toggle_q <= toggle_d;
      hold_q <= hold_d;
    end
  end

  // Destination: edge of the synchronised toggle captures the held word, which is stable by then
  always_comb begin
    dst_valid_d = sync_q ^ last_q;
    dst_data_d = dst_data;
    if (sync_q ^ last_q) begin
      dst_data_d = hold_q;
    end
  end

  always_ff @(posedge dst_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
      dst_valid <= 1'b0;
      dst_data <= '0;
    end else begin
      meta_q <= toggle_q;
      sync_q <= meta_q;
      last_q <= sync_q;
      dst_valid <= dst_valid_d;
      dst_data <= dst_data_d;
    end
  end

endmodule

/* src/thermal_cfg_regs.sv */
// Capability and configuration registers of the temperature sensor with its link-side access port
`timescale 1ns/1ps
module thermal_cfg_regs (
  // Core clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link side, clocked by the serial front end
  input wire logic link_clk,
  input wire logic link_ptr_valid,
  input wire logic [7:0] link_ptr,
  input wire logic link_wr_valid,
  input wire logic [15:0] link_wr_data,
  input wire logic link_rd_valid,
  output logic [15:0] link_rd_data,
  output logic link_done,
  output logic link_busy,
  // Sensor state from the converter and comparators
  input wire logic [1:0] res_select,
  input wire thermal_cfg_pkg::trip_s trip,
  // Controls toward the converter and limit storage
  output logic conv_enable,
  output logic [1:0] limit_hysteresis,
  output logic crit_lock,
  output logic win_lock,
  output thermal_cfg_pkg::limit_wr_s limit_wr,
  // Event pin level
  output logic event_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: pointer, request issue and answer capture

  typedef enum logic [0:0] {LS_IDLE, LS_WAIT} link_state_e;

  link_state_e ls_q, ls_d;
  logic [7:0] ptr_q, ptr_d;
  logic [15:0] link_rd_data_d;
  logic link_done_d;
  logic req_send;
  thermal_cfg_pkg::link_req_s req_out;
  logic rsp_valid;
  logic [15:0] rsp_data;

  // A new pointer or data access is taken only while no access is in flight
  always_comb begin
    ls_d = ls_q;
    ptr_d = ptr_q;
    link_rd_data_d = link_rd_data;
    link_done_d = 1'b0;
    req_send = 1'b0;
    req_out.is_write = link_wr_valid;
    req_out.ptr = ptr_q;
    req_out.data = link_wr_data;
    unique case (ls_q)
      LS_IDLE: begin
        if (link_ptr_valid) begin
          ptr_d = link_ptr; // R23
        end else if (link_wr_valid || link_rd_valid) begin
          req_send = 1'b1;
          ls_d = LS_WAIT;
        end
      end
      LS_WAIT: begin
        if (rsp_valid) begin
          link_rd_data_d = rsp_data;
          link_done_d = 1'b1;
          ls_d = LS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      ls_q <= LS_IDLE;
      ptr_q <= 8'h00;
      link_rd_data <= 16'h0000;
      link_done <= 1'b0;
      link_busy <= 1'b0;
    end else begin
      ls_q <= ls_d;
      ptr_q <= ptr_d;
      link_rd_data <= link_rd_data_d;
      link_done <= link_done_d;
      link_busy <= (ls_d == LS_WAIT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crossings in both directions

  thermal_cfg_pkg::link_req_s req_in;
  logic req_valid;
  logic rsp_send_q, rsp_send_d;
  logic [15:0] rsp_word_q, rsp_word_d;

  toggle_word_sync #(.WIDTH($bits(thermal_cfg_pkg::link_req_s))) u_req_sync (
    .src_clk(link_clk),
    .dst_clk(mclk),
    .resetn(resetn),
    .src_send(req_send),
    .src_data(req_out),
    .dst_valid(req_valid),
    .dst_data(req_in)
  );

  toggle_word_sync #(.WIDTH(16)) u_rsp_sync (
    .src_clk(mclk),
    .dst_clk(link_clk),
    .resetn(resetn),
    .src_send(rsp_send_q),
    .src_data(rsp_word_q),
    .dst_valid(rsp_valid),
    .dst_data(rsp_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: configuration register and event output

  logic [1:0] hyst_q, hyst_d;
  logic shutdown_select_q, shutdown_select_d;
  logic crit_lock_q, crit_lock_d;
  logic win_lock_q, win_lock_d;
  logic evt_en_q, evt_en_d;
  logic evt_sel_q, evt_sel_d;
  logic evt_pol_q, evt_pol_d;
  logic evt_mode_q, evt_mode_d;
  logic int_latch_q, int_latch_d;
  logic window_last_q, window_last_d;
  logic evt_active_q, evt_active_d;
  logic event_pin_d;
  thermal_cfg_pkg::limit_wr_s limit_wr_d;
  logic cfg_wr;
  logic any_lock;
  logic int_clear;
  logic window_trip;
  logic [15:0] cap_word;
  logic [15:0] cfg_word;

  // Capability is constant apart from the live resolution mirror
  always_comb begin
    cap_word = 16'h0000; // R1
    cap_word[thermal_cfg_pkg::CAP_RES_LSB +: 2] = res_select; // R2
    cap_word[thermal_cfg_pkg::CAP_RANGE] = 1'b1; // R3
    cap_word[thermal_cfg_pkg::CAP_ACCURACY] = 1'b1; // R4
    cap_word[thermal_cfg_pkg::CAP_ALARM] = 1'b1; // R5
  end

  // Configuration read view; interrupt clear always reads zero
  always_comb begin
    cfg_word = 16'h0000; // R6
    cfg_word[thermal_cfg_pkg::CFG_HYST_LSB +: 2] = hyst_q;
    cfg_word[thermal_cfg_pkg::CFG_SHUTDOWN] = shutdown_select_q;
    cfg_word[thermal_cfg_pkg::CFG_CRIT_LOCK] = crit_lock_q;
    cfg_word[thermal_cfg_pkg::CFG_WIN_LOCK] = win_lock_q;
    cfg_word[thermal_cfg_pkg::CFG_INT_CLEAR] = 1'b0; // R16
    cfg_word[thermal_cfg_pkg::CFG_EVT_STAT] = evt_active_q; // R17
    cfg_word[thermal_cfg_pkg::CFG_EVT_EN] = evt_en_q;
    cfg_word[thermal_cfg_pkg::CFG_EVT_SEL] = evt_sel_q;
    cfg_word[thermal_cfg_pkg::CFG_EVT_POL] = evt_pol_q;
    cfg_word[thermal_cfg_pkg::CFG_EVT_MODE] = evt_mode_q;
  end

  // Register writes; locks are judged on their state before this write
  always_comb begin
    hyst_d = hyst_q;
    shutdown_select_d = shutdown_select_q;
    crit_lock_d = crit_lock_q;
    win_lock_d = win_lock_q;
    evt_en_d = evt_en_q;
    evt_sel_d = evt_sel_q;
    evt_pol_d = evt_pol_q;
    evt_mode_d = evt_mode_q;
    int_clear = 1'b0;
    any_lock = crit_lock_q | win_lock_q;
    cfg_wr = req_valid && req_in.is_write && (req_in.ptr == thermal_cfg_pkg::PTR_CONFIGURATION);
    if (cfg_wr) begin
      if (!any_lock) begin
        hyst_d = req_in.data[thermal_cfg_pkg::CFG_HYST_LSB +: 2]; // R7 R8
        evt_en_d = req_in.data[thermal_cfg_pkg::CFG_EVT_EN]; // R18 R19
        evt_pol_d = req_in.data[thermal_cfg_pkg::CFG_EVT_POL]; // R21 R19
        evt_mode_d = req_in.data[thermal_cfg_pkg::CFG_EVT_MODE]; // R22 R19
      end
      if (!win_lock_q) begin
        evt_sel_d = req_in.data[thermal_cfg_pkg::CFG_EVT_SEL]; // R20
      end
      // Clearing shutdown always lands; setting it needs both locks clear
      shutdown_select_d = any_lock ? (shutdown_select_q & req_in.data[thermal_cfg_pkg::CFG_SHUTDOWN])
                                   : req_in.data[thermal_cfg_pkg::CFG_SHUTDOWN]; // R9 R11
      crit_lock_d = crit_lock_q | req_in.data[thermal_cfg_pkg::CFG_CRIT_LOCK]; // R14 R15
      win_lock_d = win_lock_q | req_in.data[thermal_cfg_pkg::CFG_WIN_LOCK]; // R14 R15
      int_clear = req_in.data[thermal_cfg_pkg::CFG_INT_CLEAR]; // R16
    end
  end

  // Limit writes are passed on unless their lock is set
  always_comb begin
    limit_wr_d.valid = 1'b0;
    limit_wr_d.ptr = req_in.ptr;
    limit_wr_d.data = req_in.data;
    if (req_valid && req_in.is_write) begin
      if (req_in.ptr == thermal_cfg_pkg::PTR_CRITICAL_LIMIT) begin
        limit_wr_d.valid = !crit_lock_q; // R12
      end else if ((req_in.ptr == thermal_cfg_pkg::PTR_UPPER_LIMIT) ||
                   (req_in.ptr == thermal_cfg_pkg::PTR_LOWER_LIMIT)) begin
        limit_wr_d.valid = !win_lock_q; // R13
      end
    end
  end

  // Answer every request so the link side can leave its wait; other pointers read zero here
  always_comb begin
    rsp_send_d = req_valid;
    rsp_word_d = rsp_word_q;
    if (req_valid) begin
      if (req_in.ptr == thermal_cfg_pkg::PTR_CAPABILITY) begin
        rsp_word_d = cap_word; // R1
      end else if (req_in.ptr == thermal_cfg_pkg::PTR_CONFIGURATION) begin
        rsp_word_d = cfg_word; // R6 R10
      end else begin
        rsp_word_d = 16'h0000;
      end
    end
  end

  // Event output; a new window crossing beats a clear in the same cycle
  always_comb begin
    window_trip = trip.upper | trip.lower;
    window_last_d = window_trip;
    int_latch_d = int_latch_q;
    if (int_clear) begin
      int_latch_d = 1'b0; // R16
    end
    if (evt_mode_q && !evt_sel_q && window_trip && !window_last_q) begin
      int_latch_d = 1'b1; // R22
    end
    if (!evt_mode_q) begin
      int_latch_d = 1'b0;
    end
    // Critical trip is always a level, the window follows the mode
    evt_active_d = evt_en_q && (trip.crit ||
                   (!evt_sel_q && (evt_mode_q ? int_latch_d : window_trip))); // R18 R20 R22
    event_pin_d = evt_pol_q ? evt_active_d : !evt_active_d; // R21
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hyst_q <= thermal_cfg_pkg::HYST_RESET;
      shutdown_select_q <= thermal_cfg_pkg::CFG_BIT_RESET;
      crit_lock_q <= thermal_cfg_pkg::CFG_BIT_RESET;
      win_lock_q <= thermal_cfg_pkg::CFG_BIT_RESET;
      evt_en_q <= thermal_cfg_pkg::CFG_BIT_RESET;
      evt_sel_q <= thermal_cfg_pkg::CFG_BIT_RESET;
      evt_pol_q <= thermal_cfg_pkg::CFG_BIT_RESET;
      evt_mode_q <= thermal_cfg_pkg::CFG_BIT_RESET;
      int_latch_q <= 1'b0;
      window_last_q <= 1'b0;
      evt_active_q <= 1'b0;
      event_pin <= 1'b1;
      rsp_send_q <= 1'b0;
      rsp_word_q <= 16'h0000;
      limit_wr <= '0;
      conv_enable <= 1'b1;
      limit_hysteresis <= thermal_cfg_pkg::HYST_RESET;
      crit_lock <= 1'b0;
      win_lock <= 1'b0;
    end else begin
      hyst_q <= hyst_d;
      shutdown_select_q <= shutdown_select_d;
      crit_lock_q <= crit_lock_d;
      win_lock_q <= win_lock_d;
      evt_en_q <= evt_en_d;
      evt_sel_q <= evt_sel_d;
      evt_pol_q <= evt_pol_d;
      evt_mode_q <= evt_mode_d;
      int_latch_q <= int_latch_d;
      window_last_q <= window_last_d;
      evt_active_q <= evt_active_d;
      event_pin <= event_pin_d;
      rsp_send_q <= rsp_send_d;
      rsp_word_q <= rsp_word_d;
      limit_wr <= limit_wr_d;
      conv_enable <= !shutdown_select_d; // R9
      limit_hysteresis <= hyst_d;
      crit_lock <= crit_lock_d;
      win_lock <= win_lock_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  cap_readback_a: assert property ( // R2
    @(posedge mclk) disable iff (!resetn)
    (req_valid && req_in.ptr == thermal_cfg_pkg::PTR_CAPABILITY)
      |=> (rsp_send_q && rsp_word_q == {11'h000, $past(res_select), 3'h7}))
    else $error("capability answer wrong");

  lock_sticky_a: assert property ( // R14
    @(posedge mclk) disable iff (!resetn)
    (crit_lock_q || win_lock_q) |=> (!$past(crit_lock_q) || crit_lock_q) && (!$past(win_lock_q) || win_lock_q))
    else $error("lock bit dropped");

  lock_single_write_a: assert property ( // R15
    @(posedge mclk) disable iff (!resetn)
    (cfg_wr && req_in.data[thermal_cfg_pkg::CFG_CRIT_LOCK]) |=> crit_lock_q ##1 crit_lock)
    else $error("lock not set by one write");

  shutdown_locked_a: assert property ( // R11
    @(posedge mclk) disable iff (!resetn)
    (cfg_wr && any_lock && !shutdown_select_q) |=> !shutdown_select_q && conv_enable)
    else $error("shutdown set while locked");

  hyst_frozen_a: assert property ( // R8
    @(posedge mclk) disable iff (!resetn)
    (cfg_wr && any_lock) |=> $stable(hyst_q) && $stable(evt_en_q) && $stable(evt_pol_q) && $stable(evt_mode_q))
    else $error("locked field changed");

  sel_frozen_a: assert property ( // R20
    @(posedge mclk) disable iff (!resetn)
    (cfg_wr && win_lock_q) |=> $stable(evt_sel_q))
    else $error("select changed under window lock");

  limit_block_a: assert property ( // R12
    @(posedge mclk) disable iff (!resetn)
    (req_valid && req_in.is_write && req_in.ptr == thermal_cfg_pkg::PTR_CRITICAL_LIMIT && crit_lock_q)
      |=> !limit_wr.valid)
    else $error("critical limit write passed under lock");

  int_clear_a: assert property ( // R16
    @(posedge mclk) disable iff (!resetn)
    (int_clear && !(window_trip && !window_last_q)) |=> !int_latch_q)
    else $error("interrupt not cleared");

  pin_polarity_a: assert property ( // R21
    @(posedge mclk) disable iff (!resetn)
    ##1 (event_pin == ($past(evt_pol_q) ? evt_active_q : !evt_active_q)))
    else $error("event pin polarity wrong");

  comparator_level_a: assert property ( // R22
    @(posedge mclk) disable iff (!resetn)
    (evt_en_q && !evt_mode_q && !evt_sel_q && window_trip) |=> evt_active_q)
    else $error("comparator event missing");

  disabled_event_a: assert property ( // R18
    @(posedge mclk) disable iff (!resetn)
    !evt_en_q |=> !evt_active_q)
    else $error("event active while disabled");

endmodule

/* dv/link_host_model.sv */
// Behavioural host driving the link access port of the register bank
`timescale 1ns/1ps
module link_host_model (
  // Link clock and answers
  input wire logic link_clk,
  input wire logic link_busy,
  input wire logic link_done,
  input wire logic [15:0] link_rd_data,
  // Requests
  output logic link_ptr_valid,
  output logic [7:0] link_ptr,
  output logic link_wr_valid,
  output logic [15:0] link_wr_data,
  output logic link_rd_valid
);
  ////////////////////////////////////////
  // Idle levels from time zero
  initial begin
    link_ptr_valid = 1'b0;
    link_wr_valid = 1'b0;
    link_rd_valid = 1'b0;
    link_ptr = 8'h00;
    link_wr_data = 16'h0000;
  end

  // One access: kind 0 pointer, 1 write, 2 read; one strobe, held over the taking edge
  task automatic acc(input int kind, input logic [15:0] v, output logic [15:0] rd, output bit ok);
    int n;
    ok = 1'b0;
    rd = 'x;
    @(posedge link_clk);
    for (n = 0; n < 20 && link_busy !== 1'b0; n++) @(posedge link_clk);
    #1;
    if (kind == 0) begin
      link_ptr = {5'h00, v[2:0]};
      link_ptr_valid = 1'b1;
    end else if (kind == 1) begin
      link_wr_data = v;
      link_wr_valid = 1'b1;
    end else begin
      link_rd_valid = 1'b1;
    end
    @(posedge link_clk);
    #1;
    link_ptr_valid = 1'b0;
    link_wr_valid = 1'b0;
    link_rd_valid = 1'b0;
    // Released lines show the inverse so a stale value cannot pass for a held one
    link_ptr = ~link_ptr;
    link_wr_data = ~link_wr_data;
    // A pointer load may finish without an answer, so a missing one is not an error here
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge link_clk);
      if (link_done === 1'b1) begin
        ok = 1'b1;
        rd = link_rd_data;
      end
    end
  endtask
endmodule

/* dv/thermal_cfg_regs_tb.sv */
// Self-checking bench for the sensor capability and configuration registers
`timescale 1ns/1ps
module thermal_cfg_regs_tb;
  // Clocks, reset and pins
  logic mclk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic link_ptr_valid, link_wr_valid, link_rd_valid, link_done, link_busy;
  logic [7:0] link_ptr;
  logic [15:0] link_wr_data, link_rd_data, cfg, rd;
  logic [1:0] res_select = thermal_cfg_pkg::RES_RESET;
  logic [1:0] limit_hysteresis;
  thermal_cfg_pkg::trip_s trip = '0;
  thermal_cfg_pkg::limit_wr_s limit_wr, lw_last;
  logic conv_enable, crit_lock, win_lock, event_pin;
  int n_fail = 0;
  int n_tests = 0;
  int lw_cnt = 0;
  bit ok;

  always #2 mclk = ~mclk;
  // Link clock offset so its edges never meet the core clock's
  initial begin
    #0.7;
    forever #6 link_clk = ~link_clk;
  end

  link_host_model i_host (.link_clk(link_clk), .link_busy(link_busy), .link_done(link_done),
    .link_rd_data(link_rd_data), .link_ptr_valid(link_ptr_valid), .link_ptr(link_ptr),
    .link_wr_valid(link_wr_valid), .link_wr_data(link_wr_data), .link_rd_valid(link_rd_valid));

  thermal_cfg_regs i_dut (.mclk(mclk), .resetn(resetn), .link_clk(link_clk),
    .link_ptr_valid(link_ptr_valid), .link_ptr(link_ptr), .link_wr_valid(link_wr_valid),
    .link_wr_data(link_wr_data), .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data),
    .link_done(link_done), .link_busy(link_busy), .res_select(res_select), .trip(trip),
    .conv_enable(conv_enable), .limit_hysteresis(limit_hysteresis), .crit_lock(crit_lock),
    .win_lock(win_lock), .limit_wr(limit_wr), .event_pin(event_pin));

  // Count limit write pulses; each lasts one core cycle
  always @(posedge mclk) begin
    if (limit_wr.valid === 1'b1) begin
      lw_cnt <= lw_cnt + 1;
      lw_last <= limit_wr;
    end
  end

  ////////////////////////////////////////
  // Expected configuration after a write; locks are judged on the state before it
  function automatic logic [15:0] nxt(logic [15:0] c, logic [15:0] w);
    logic [15:0] n;
    n = c & 16'h07CF;
    if (!(c[7] | c[6])) begin
      n[10:8] = w[10:8];
      n[3] = w[3];
      n[1:0] = w[1:0];
    end else if (!w[8]) begin
      n[8] = 1'b0;
    end
    if (!c[6]) n[2] = w[2];
    n[7:6] = c[7:6] | w[7:6];
    return n;
  endfunction

  // Comparator-mode event level
  function automatic logic act(logic [15:0] c, thermal_cfg_pkg::trip_s t);
    return c[3] & (t.crit | ~c[2] & (t.upper | t.lower));
  endfunction

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rw(input logic [7:0] p, input int kind, input logic [15:0] v);
    i_host.acc(0, {8'h00, p}, rd, ok);
    i_host.acc(kind, v, rd, ok);
    if (!ok) chk("link_done", 16'h0001, 16'h0000);
  endtask

  task automatic wcfg(input logic [15:0] w);
    rw(thermal_cfg_pkg::PTR_CONFIGURATION, 1, w);
    cfg = nxt(cfg, w);
    repeat (4) @(posedge mclk);
  endtask

  task automatic check_cfg(input logic ev);
    rw(thermal_cfg_pkg::PTR_CONFIGURATION, 2, 16'h0000);
    chk("config", cfg | {11'h000, ev, 4'h0}, rd);
    chk("controls", {11'h000, cfg[10:9], ~cfg[8], cfg[7:6]},
      {11'h000, limit_hysteresis, conv_enable, crit_lock, win_lock});
    chk("event_pin", {15'h0000, cfg[1] ~^ ev}, {15'h0000, event_pin});
  endtask

  task automatic lim(input logic [7:0] p, input logic blocked);
    int c0;
    logic [15:0] v;
    v = 16'($urandom()) & 16'h1FFC;
    c0 = lw_cnt;
    rw(p, 1, v);
    repeat (4) @(posedge mclk);
    chk("limit writes", {15'h0000, ~blocked}, 16'(lw_cnt - c0));
    if (!blocked) chk("limit data", v, lw_last.data);
    if (!blocked) chk("limit ptr", {8'h00, p}, {8'h00, lw_last.ptr});
  endtask

  task automatic do_reset();
    @(posedge mclk);
    #1;
    resetn = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    resetn = 1'b1;
    cfg = 16'h0000;
    repeat (3) @(posedge link_clk);
  endtask

  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Tests in sequence
  initial begin
    void'($urandom(20));
    do_reset();
    check_cfg(1'b0);
    // Capability follows every resolution code and ignores writes
    for (int r = 0; r < 4; r++) begin
      @(posedge mclk);
      #1;
      res_select = 2'(r + 1);
      rw(thermal_cfg_pkg::PTR_CAPABILITY, 1, 16'hFFFF);
      rw(thermal_cfg_pkg::PTR_CAPABILITY, 2, 16'h0000);
      chk("capability", {11'h000, 2'(r + 1), 3'b111}, rd);
    end
    rw(8'h05, 2, 16'h0000);
    chk("unmapped", 16'h0000, rd);
    $display("capability test done");
    // Random comparator-mode settings, shutdown included, against random trips
    for (int i = 0; i < 40; i++) begin
      wcfg(16'($urandom()) & 16'hFF3E);
      @(posedge mclk);
      #1;
      trip = thermal_cfg_pkg::trip_s'(3'($urandom()));
      repeat (4) @(posedge mclk);
      check_cfg(act(cfg, trip));
    end
    $display("random config test done");
    // Latched interrupt survives trip removal and a zero clear bit
    @(posedge mclk);
    #1;
    trip = '0;
    wcfg(16'h000B);
    @(posedge mclk);
    #1;
    trip = 3'b010;
    repeat (4) @(posedge mclk);
    #1;
    trip = '0;
    repeat (4) @(posedge mclk);
    check_cfg(1'b1);
    wcfg(16'h000B);
    check_cfg(1'b1);
    wcfg(16'h002B);
    check_cfg(1'b0);
    $display("interrupt test done");
    // Locks: single write sets them, frozen fields, shutdown only clearable
    wcfg(16'h0000);
    wcfg(16'h0100);
    wcfg(16'h0180);
    check_cfg(1'b0);
    wcfg(16'h1E0F);
    check_cfg(1'b0);
    wcfg(16'h0100);
    check_cfg(1'b0);
    lim(thermal_cfg_pkg::PTR_CRITICAL_LIMIT, 1'b1);
    lim(thermal_cfg_pkg::PTR_UPPER_LIMIT, 1'b0);
    lim(thermal_cfg_pkg::PTR_LOWER_LIMIT, 1'b0);
    wcfg(16'h0040);
    wcfg(16'h0004);
    wcfg(16'h0000);
    check_cfg(1'b0);
    lim(thermal_cfg_pkg::PTR_UPPER_LIMIT, 1'b1);
    lim(thermal_cfg_pkg::PTR_LOWER_LIMIT, 1'b1);
    $display("lock test done");
    // Only reset releases the locks
    do_reset();
    check_cfg(1'b0);
    lim(thermal_cfg_pkg::PTR_CRITICAL_LIMIT, 1'b0);
    $display("reset test done");
    wrap_up();
  end

  // Watchdog: the run needs well under 100 us, so 300 us means a hang
  initial begin
    #300000;
    n_fail++;
    wrap_up();
  end
endmodule
